/* File: hw/sensor_cfg_port.sv */
`timescale 1ns/1ps
module sensor_cfg_port #(
  parameter int ADDR_W = cfg_port_pkg::ADDR_W,
  parameter int DATA_W = cfg_port_pkg::DATA_W
) (
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Reset, active high: synchronous on the system side, asynchronous for the posted word.
  cfg_link_if.dev link, // Serial port toward the master.
  output logic cfg_wr_valid, // Pulse: a register was written.
  output logic [ADDR_W-1:0] cfg_wr_addr, // Address of that register.
  output logic [DATA_W-1:0] cfg_wr_data, // Value written.
  output logic sel_active // Select seen low, synchronised.
);

  localparam int REGS = 1 << ADDR_W;
  localparam int CW = cfg_port_pkg::CNT_W;

  // ----------------------------------------------------------------
  // Serial clock domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [ADDR_W-1:0] addr;
    logic wr;
    logic [DATA_W-1:0] sh;
    logic drive;
  } frame_t;

  typedef struct packed {
    logic tgl;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } post_t;

  frame_t frame_q;
  frame_t frame_d;
  post_t post_q;
  post_t post_d;
  logic img_we;
  logic [DATA_W-1:0] image_q [REGS];
  logic [DATA_W-1:0] rd_word;

  // ----------------------------------------------------------------
  // System clock domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic seen;
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sys_t;

  sys_t sys_q;
  sys_t sys_d;
  logic tgl_s;
  logic sel_s;

  // ----------------------------------------------------------------
  // Frame decoder
  // ----------------------------------------------------------------
  assign rd_word = image_q[frame_q.addr];

  always_comb begin
    frame_d = frame_q;
    post_d = post_q;
    img_we = 1'b0;
    if (frame_q.cnt != cfg_port_pkg::DONE_IDX) begin
      frame_d.cnt = frame_q.cnt + 1'b1;
    end
    if (frame_q.cnt < CW'(ADDR_W)) begin
      // Address bits arrive most significant first.
      frame_d.addr = {frame_q.addr[ADDR_W-2:0], link.mosi};
    end else if (frame_q.cnt == cfg_port_pkg::DIR_IDX) begin
      frame_d.wr = (link.mosi == cfg_port_pkg::DIR_WRITE);
      if (link.mosi == cfg_port_pkg::DIR_READ) begin
        // Loading here puts the MSB on the line before the next fall.
        frame_d.sh = rd_word;
        frame_d.drive = 1'b1;
      end
    end else if (frame_q.cnt != cfg_port_pkg::DONE_IDX) begin
      // One shift serves both directions: write data enters at the
      // bottom while read data leaves from the top.
      frame_d.sh = {frame_q.sh[DATA_W-2:0], link.mosi};
      if (frame_q.cnt == cfg_port_pkg::LAST_IDX) begin
        frame_d.drive = 1'b0;
        if (frame_q.wr) begin
          img_we = 1'b1;
          post_d.tgl = ~post_q.tgl;
          post_d.addr = frame_q.addr;
          post_d.data = frame_d.sh;
        end
      end
    end
  end

  // Select high clears the frame at once, so a short access never
  // reaches the commit step and leaves no trace.
  always_ff @(posedge link.sck or posedge link.ss_n) begin
    if (link.ss_n) begin
      frame_q <= '0;
    end else begin
      frame_q <= frame_d;
    end
  end

  // The serial clock may stop between frames, so the posted word is
  // reset by the system reset without waiting for a serial edge.
  always_ff @(posedge link.sck or posedge sys_rst) begin
    if (sys_rst) begin
      post_q <= '0;
    end else begin
      post_q <= post_d;
    end
  end

  always_ff @(posedge link.sck) begin
    if (img_we) begin
      image_q[frame_q.addr] <= frame_d.sh;
    end
  end

  assign link.miso_o = frame_q.sh[DATA_W-1];
  assign link.miso_oe_n = ~frame_q.drive;

  // ----------------------------------------------------------------
  // Crossing into the system clock domain
  // ----------------------------------------------------------------
  sync2 u_tgl_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(post_q.tgl),
    .q(tgl_s)
  );

  sync2 u_sel_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(~link.ss_n),
    .q(sel_s)
  );

  // The posted word stays still for a whole frame after its toggle
  // flips, far longer than the synchroniser takes to show it.
  always_comb begin
    sys_d = sys_q;
    sys_d.valid = 1'b0;
    sys_d.seen = tgl_s;
    if (tgl_s != sys_q.seen) begin
      sys_d.valid = 1'b1;
      sys_d.addr = post_q.addr;
      sys_d.data = post_q.data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sys_q <= '0;
    end else begin
      sys_q <= sys_d;
    end
  end

  assign cfg_wr_valid = sys_q.valid;
  assign cfg_wr_addr = sys_q.addr;
  assign cfg_wr_data = sys_q.data;
  assign sel_active = sel_s;

endmodule

/* File: hw/cfg_port_pkg.sv */
package cfg_port_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam int FRAME_BITS = ADDR_W + 1 + DATA_W;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] DIR_IDX = 5'h09;
  localparam logic [CNT_W-1:0] LAST_IDX = 5'h19;
  localparam logic [CNT_W-1:0] DONE_IDX = 5'h1A;
  localparam logic DIR_WRITE = 1'b1;
  localparam logic DIR_READ = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 64'h0000_0000_0262_5A00;
  localparam longint SCK_MAX_HZ = 64'h0000_0000_0098_9680;
  localparam int SCK_HALF =
    int'((CLK_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ));
  localparam int LEAD_PERIODS = 1;
  localparam int TAIL_PERIODS = 1;
  localparam int GAP_PERIODS = 2;
  localparam int TICK_W = 8;

endpackage

/* File: hw/cfg_link_if.sv */
`timescale 1ns/1ps
interface cfg_link_if;

  logic sck;
  logic ss_n;
  logic mosi;
  logic miso_o;
  logic miso_oe_n;
  logic miso;

  // The serial output line idles high while nobody drives it.
  assign miso = miso_oe_n ? 1'b1 : miso_o;

  modport dev (
    input sck,
    input ss_n,
    input mosi,
    output miso_o,
    output miso_oe_n
  );

  modport mst (
    output sck,
    output ss_n,
    output mosi,
    input miso
  );

endinterface

/* File: hw/sync2.sv */
`timescale 1ns/1ps
module sync2 (
  input wire logic clk, // Destination clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic d, // Level from another domain.
  output logic q // Synchronised level.
);

  typedef struct packed {
    logic meta;
    logic sync;
  } sync_t;

  sync_t s_q;
  sync_t s_d;

  always_comb begin
    s_d.meta = d;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.sync;

endmodule

/* File: hw/cfg_master.sv */
`timescale 1ns/1ps
module cfg_master #(
  parameter int ADDR_W = cfg_port_pkg::ADDR_W,
  parameter int DATA_W = cfg_port_pkg::DATA_W,
  parameter int SCK_HALF = cfg_port_pkg::SCK_HALF
) (
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  cfg_link_if.mst link, // Serial port toward the sensor.
  input wire logic req_valid, // Access request.
  output logic req_ready, // Idle, request taken.
  input wire logic req_write, // One writes, zero reads.
  input wire logic [ADDR_W-1:0] req_addr, // Register address.
  input wire logic [DATA_W-1:0] req_wdata, // Write data.
  output logic done, // Pulse: access finished.
  output logic [DATA_W-1:0] rd_data // Read data, valid with done.
);

  localparam int FB = ADDR_W + 1 + DATA_W;
  localparam int TW = cfg_port_pkg::TICK_W;
  localparam int LEAD_CYC = 2 * SCK_HALF * cfg_port_pkg::LEAD_PERIODS;
  localparam int TAIL_CYC = 2 * SCK_HALF * cfg_port_pkg::TAIL_PERIODS;
  localparam int GAP_CYC = 2 * SCK_HALF * cfg_port_pkg::GAP_PERIODS;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    M_IDLE, M_LEAD, M_HIGH, M_LOW, M_TAIL, M_GAP
  } mstate_t;

  typedef struct packed {
    mstate_t st;
    logic [TW-1:0] tick;
    logic [cfg_port_pkg::CNT_W-1:0] bits;
    logic [FB-1:0] tx;
    logic [DATA_W-1:0] rx;
    logic sck;
    logic ss_n;
    logic done;
    logic [DATA_W-1:0] rd;
  } mst_t;

  mst_t m_q;
  mst_t m_d;
  logic miso_s;

  function automatic logic phase_end(logic [TW-1:0] tick, int len);
    return tick == TW'(len - 1);
  endfunction

  sync2 u_miso_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(link.miso),
    .q(miso_s)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    m_d = m_q;
    m_d.done = 1'b0;
    m_d.tick = m_q.tick + 1'b1;
    case (m_q.st)
      M_IDLE: begin
        m_d.tick = '0;
        if (req_valid) begin
          m_d.tx = {req_addr, req_write,
                    req_write ? req_wdata : DATA_W'(0)};
          m_d.ss_n = 1'b0;
          m_d.bits = '0;
          m_d.st = M_LEAD;
        end
      end
      M_LEAD: begin
        if (phase_end(m_q.tick, LEAD_CYC)) begin
          m_d.tick = '0;
          m_d.sck = 1'b1;
          m_d.st = M_HIGH;
        end
      end
      M_HIGH: begin
        if (phase_end(m_q.tick, SCK_HALF)) begin
          m_d.tick = '0;
          m_d.sck = 1'b0;
          m_d.bits = m_q.bits + 1'b1;
          if (m_q.bits == cfg_port_pkg::LAST_IDX) begin
            m_d.st = M_TAIL;
          end else begin
            m_d.tx = {m_q.tx[FB-2:0], 1'b0};
            m_d.st = M_LOW;
          end
        end
      end
      M_LOW: begin
        if (phase_end(m_q.tick, SCK_HALF)) begin
          // The synchroniser delay makes this the line level at the fall.
          m_d.rx = {m_q.rx[DATA_W-2:0], miso_s};
          m_d.tick = '0;
          m_d.sck = 1'b1;
          m_d.st = M_HIGH;
        end
      end
      M_TAIL: begin
        if (phase_end(m_q.tick, TAIL_CYC)) begin
          m_d.tick = '0;
          m_d.ss_n = 1'b1;
          m_d.done = 1'b1;
          m_d.rd = m_q.rx;
          m_d.st = M_GAP;
        end
      end
      M_GAP: begin
        if (phase_end(m_q.tick, GAP_CYC)) begin
          m_d.tick = '0;
          m_d.st = M_IDLE;
        end
      end
      default: begin
        m_d.st = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      m_q <= '0;
      m_q.ss_n <= 1'b1;
    end else begin
      m_q <= m_d;
    end
  end

  assign req_ready = (m_q.st == M_IDLE);
  assign link.sck = m_q.sck;
  assign link.ss_n = m_q.ss_n;
  assign link.mosi = m_q.tx[FB-1];
  assign done = m_q.done;
  assign rd_data = m_q.rd;

endmodule

/* File: dv/cfg_link_checker.sv */
`timescale 1ns/1ps
module cfg_link_checker (
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic sck, // Serial clock.
  input wire logic ss_n, // Select, active low.
  input wire logic mosi, // Master data.
  input wire logic miso_oe_n // Device output enable, active low.
);
  logic sck_q;
  logic dir_q;
  logic [4:0] rise_q;

  // Counts serial rising edges within the current frame.
  always_ff @(posedge clk) begin
    sck_q <= sck;
    if (ss_n) begin
      rise_q <= 5'h00;
    end else if (sck && !sck_q) begin
      rise_q <= rise_q + 5'h01;
      if (rise_q == 5'h09) begin
        dir_q <= mosi;
      end
    end
  end

  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_oe_idle; ss_n |-> miso_oe_n; endproperty
  property p_lead; $fell(ss_n) |-> !sck [*4] ##1 sck; endproperty
  property p_sck_hi; $rose(sck) |=> sck ##1 !sck; endproperty
  property p_sck_lo;
    $fell(sck) && rise_q != 5'h1A |=> !sck ##1 sck;
  endproperty
  property p_mosi;
    !ss_n && $changed(mosi) |-> $fell(sck) || $fell(ss_n);
  endproperty
  property p_count; $rose(ss_n) |-> rise_q == 5'h1A; endproperty
  property p_tail;
    $fell(sck) && rise_q == 5'h1A |-> !ss_n [*4] ##1 ss_n;
  endproperty
  property p_gap; $rose(ss_n) |-> ss_n [*8]; endproperty
  property p_oe_read;
    $fell(sck) && rise_q == 5'h0A |-> miso_oe_n == dir_q;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("miso driven while deselected");
  a_lead: assert property (p_lead)
    else $error("wrong lead before first clock");
  a_sck_hi: assert property (p_sck_hi)
    else $error("serial high phase wrong");
  a_sck_lo: assert property (p_sck_lo)
    else $error("serial low phase wrong");
  a_mosi: assert property (p_mosi)
    else $error("mosi changed off falling edge");
  a_count: assert property (p_count)
    else $error("frame length is not 26 clocks");
  a_tail: assert property (p_tail)
    else $error("wrong tail before deselect");
  a_gap: assert property (p_gap)
    else $error("gap between frames too short");
  a_oe_read: assert property (p_oe_read)
    else $error("output enable disagrees with direction");
  c_write: cover property ($rose(ss_n) && dir_q);
  c_read: cover property ($rose(ss_n) && !dir_q);
  c_drive: cover property (!miso_oe_n && !ss_n);
endmodule

/* File: dv/sensor_cfg_port_tb.sv */
`timescale 1ns/1ps
module sensor_cfg_port_tb;
  logic clk = 1'b0;
  logic sys_rst;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [8:0] req_addr = 9'h000;
  logic [15:0] req_wdata = 16'h0000;
  logic req_ready, done, wr_v, wr2_v, sel2;
  logic [15:0] rd_data, wr_d, wr2_d, got;
  logic [8:0] wr_a, wr2_a;
  logic [8:0] ta [3] = '{9'h000, 9'h1FF, 9'h0AB};
  logic [15:0] td [3] = '{16'hA5C3, 16'h5A3C, 16'h8001};
  int fails = 0;
  int checked = 0;
  int wr_n = 0;
  int wr2_n = 0;
  cfg_link_if link ();
  cfg_link_if link2 ();
  sensor_cfg_port sensor_cfg_port_i (.clk(clk), .sys_rst(sys_rst),
    .link(link.dev), .cfg_wr_valid(wr_v), .cfg_wr_addr(wr_a),
    .cfg_wr_data(wr_d), .sel_active());
  sensor_cfg_port sensor_cfg_port_i2 (.clk(clk), .sys_rst(sys_rst),
    .link(link2.dev), .cfg_wr_valid(wr2_v), .cfg_wr_addr(wr2_a),
    .cfg_wr_data(wr2_d), .sel_active(sel2));
  cfg_master cfg_master_i (.clk(clk), .sys_rst(sys_rst), .link(link.mst),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .done(done),
    .rd_data(rd_data));
  cfg_link_checker cfg_link_checker_i (.clk(clk), .sys_rst(sys_rst),
    .sck(link.sck), .ss_n(link.ss_n), .mosi(link.mosi),
    .miso_oe_n(link.miso_oe_n));

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    wr_n += (wr_v === 1'b1);
    wr2_n += (wr2_v === 1'b1);
  end

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic mop(input logic w, input int k);
    int n;
    n = wr_n;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= ta[k];
    req_wdata <= w ? td[k] : 16'h0000;
    for (int i = 0; i < 20 && req_ready !== 1'b1; i++) @(posedge clk);
    @(posedge clk);
    req_valid <= 1'b0;
    for (int i = 0; i < 200 && done !== 1'b1; i++) @(posedge clk) #1;
    chk({15'h0000, done}, 16'h0001);
    chk(16'(wr_n - n), {15'h0000, w});
    if (w) chk({7'h00, wr_a}, {7'h00, ta[k]});
    chk(w ? wr_d : rd_data, td[k]);
  endtask
  // Frame of nb bits on the second link, serial clock made here.
  task automatic bfr(input int nb, input logic [25:0] f);
    got = 16'h0000;
    link2.ss_n = 1'b0;
    #30;
    for (int i = 25; i > 25 - nb; i--) begin
      link2.mosi = f[i];
      #15 link2.sck = 1'b1;
      #15 link2.sck = 1'b0;
      // The fall after the last rise finds the line released.
      if (i > 0) begin
        got = {got[14:0], link2.miso};
      end
    end
    chk({15'h0000, sel2}, 16'h0001);
    #30 link2.ss_n = 1'b1;
    link2.mosi = ~link2.mosi;
    #90;
    chk({15'h0000, sel2}, 16'h0000);
  endtask

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  task automatic test_master;
    for (int k = 0; k < 3; k++) mop(1'b1, k);
    for (int k = 0; k < 3; k++) mop(1'b0, k);
    $display("test_master done");
  endtask
  task automatic test_abort;
    bfr(26, {9'h055, 1'b1, 16'h1234});
    chk(got, 16'hFFFF);
    chk(16'(wr2_n), 16'h0001);
    chk({7'h00, wr2_a}, 16'h0055);
    chk(wr2_d, 16'h1234);
    bfr(20, {9'h055, 1'b1, 16'hBEEF});
    bfr(9, {9'h055, 1'b1, 16'hBEEF});
    chk(16'(wr2_n), 16'h0001);
    bfr(26, {9'h055, 1'b0, 16'h0000});
    chk(got, 16'h1234);
    $display("test_abort done");
  endtask

  initial begin
    // A scheduled rise at time zero gives the serial-side flops an edge.
    sys_rst <= 1'b1;
    link2.sck = 1'b0;
    link2.ss_n = 1'b1;
    link2.mosi = 1'b0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    test_master();
    test_abort();
    stop_test();
  end
  initial begin
    #100000;
    fails++;
    stop_test();
  end
endmodule
